// >>> bench/dor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dor_consts.vh"
// ****
// Port checks
// ****
module dor_asserts
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [3:0]  out_pin_o,
  input wire logic [3:0]  out_oe_o,
  input wire logic        brake_o,
  input wire logic        led_green_o,
  input wire logic        led_red_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Completed accesses, seen in their single ready cycle
  wire logic rd_w = psel_i & penable_i & pready_o & ~pwrite_i;
  wire logic wr_w = psel_i & penable_i & pready_o & pwrite_i;
  chk_setup_ready:
  assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  chk_ready_pulse:
  assert property (pready_o |=> !pready_o) else $error("ready held too long");
  chk_no_slverr:
  assert property (!pslverr_o) else $error("slave error raised");
  chk_led_follow:
  assert property (wr_w && paddr_i == `DOR_OFF_LED |->
    ##3 {led_red_o, led_green_o} == $past(pwdata_i[1:0], 3)) else $error("led mismatch");
  chk_readback_pins:
  assert property (rd_w && paddr_i == `DOR_OFF_READBACK |->
    prdata_o[19:16] == $past(out_pin_o) && prdata_o[0] == $past(brake_o)) else $error("readback differs");
  chk_unmapped_zero:
  assert property (rd_w && paddr_i == 12'h030 |-> prdata_o == 32'h0) else $error("unmapped read");
  chk_route_upper:
  assert property (rd_w && paddr_i >= `DOR_OFF_ROUTE0 && paddr_i < 12'h054 |->
    prdata_o[31:16] == 16'h0) else $error("route word upper bits");
  // Open drain: the enable pulls low, so it must be the inverse of the level
  chk_oe_inverse:
  assert property ($past(rst_b_i) |-> out_oe_o == ~out_pin_o) else $error("enable not inverse");
endmodule // dor_asserts
bind dor_top dor_asserts i_chk
(
  .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .out_pin_o(out_pin_o), .out_oe_o(out_oe_o),
  .brake_o(brake_o), .led_green_o(led_green_o), .led_red_o(led_red_o)
);
`default_nettype wire

// >>> bench/dor_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Pull-up loads
// ****
module dor_load_model
(
  input  wire logic [3:0] oe_i,
  output wire logic [3:0] line_o
);
  // A released pin floats up through its resistor
  assign line_o = ~oe_i;
endmodule // dor_load_model
`default_nettype wire

// >>> bench/dor_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dor_consts.vh"
// ****
// Bench
// ****
module dor_top_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, c, p, m, f, a;
  logic        pready, pslverr, brake, swpwm, ledg, ledr;
  logic [3:0]  pin, oe, line;
  logic [11:0] ad;
  logic [15:0] w;
  logic [7:0]  cw;
  logic [1:0]  ex;
  int          err_total = 0;
  int          n_checks = 0;
  logic [43:0] rst_t [12] = '{{`DOR_OFF_CMD, 32'h0}, {`DOR_OFF_POL, 32'h0}, {`DOR_OFF_MASK, 32'h0},
    {`DOR_OFF_FORCE, 32'h0}, {`DOR_OFF_READBACK, 32'h0}, {`DOR_OFF_ROUTE_EN, 32'h0},
    {`DOR_OFF_LED, 32'h0}, {`DOR_OFF_PWM_FREQ, 32'h3e8}, {`DOR_OFF_PWM_DUTY, 32'h32},
    {`DOR_OFF_ROUTE0, 32'hffff}, {12'h050, 32'hffff}, {12'h030, 32'h0}};
  // Command, polarity, mask, force
  logic [127:0] nrm_t [6] = '{{32'h00010001, 32'h0, 32'h0, 32'h0}, {32'h000a0000, 32'h0, 32'h0, 32'h0},
    {32'h00030000, 32'h00010000, 32'h0, 32'h0}, {32'h000f0001, 32'h0, 32'h00040001, 32'h0},
    {32'h0, 32'h00080000, 32'h00010000, 32'h00010000}, {32'h00100000, 32'h0, 32'h0, 32'h0}};
  logic [75:0] lim_t [8] = '{{12'h01c, 32'h31, 32'h3e8}, {12'h01c, 32'h32, 32'h32},
    {12'h01c, 32'h7d0, 32'h7d0}, {12'h01c, 32'h7d1, 32'h7d0}, {12'h020, 32'h1, 32'h32},
    {12'h020, 32'h2, 32'h2}, {12'h020, 32'h65, 32'h2}, {12'h020, 32'h64, 32'h64}};
  // Route word, command, expected soft PWM and output 1
  logic [25:0] rte_t [9] = '{{16'h0005, 8'h20, 2'b11}, {16'h0005, 8'h00, 2'b00},
    {16'h0105, 8'h20, 2'b00}, {16'h0085, 8'h00, 2'b11}, {16'h0085, 8'h20, 2'b00},
    {16'h1000, 8'h01, 2'b11}, {16'h1100, 8'h01, 2'b00}, {16'h1000, 8'h00, 2'b00},
    {16'hffff, 8'h20, 2'b01}};

  dor_top i_dut
  (
    .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .out_pin_o(pin), .out_oe_o(oe), .brake_o(brake),
    .swpwm_o(swpwm), .led_green_o(ledg), .led_red_o(ledr)
  );
  dor_load_model i_load
  (
    .oe_i(oe),
    .line_o(line)
  );

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // One APB transfer; request held until ready is seen at an edge
  task apb(input logic wr, input logic [11:0] ad_i, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= ad_i;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_total++;
      close_out;
    end
  endtask

  // Pins move one edge after the write edge, routed pulses three edges after it
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Writes to read-only and unmapped places must leave no trace
    apb(1'b1, `DOR_OFF_READBACK, 32'hffffffff);
    apb(1'b1, 12'h030, 32'hffffffff);
    foreach (rst_t[i])
    begin
      apb(1'b0, rst_t[i][43:32], 32'h0);
      chk(rst_t[i][31:0], q);
    end
    settle;
    chk(32'h0, {28'h0, line});
    $display("reset test done");
    foreach (nrm_t[i])
    begin
      {c, p, m, f} = nrm_t[i];
      apb(1'b1, `DOR_OFF_CMD, c);
      apb(1'b1, `DOR_OFF_POL, p);
      apb(1'b1, `DOR_OFF_MASK, m);
      apb(1'b1, `DOR_OFF_FORCE, f);
      a = ((m & f) | (~m & c)) ^ p;
      settle;
      chk({27'h0, a[19:16], a[0]}, {27'h0, line, brake});
      apb(1'b0, `DOR_OFF_READBACK, 32'h0);
      chk(a & 32'h000f0001, q & 32'h000f0001);
    end
    $display("normal path test done");
    for (int v = 0; v < 4; v++)
    begin
      apb(1'b1, `DOR_OFF_LED, v);
      settle;
      chk(v, {30'h0, ledr, ledg});
    end
    $display("led test done");
    foreach (lim_t[i])
    begin
      {ad, c, p} = lim_t[i];
      apb(1'b1, ad, c);
      apb(1'b0, ad, 32'h0);
      chk(p, q);
    end
    $display("limit test done");
    // Normal path would give output 1 high here, so a low shows it is bypassed
    apb(1'b1, `DOR_OFF_POL, 32'hffffffff);
    apb(1'b1, `DOR_OFF_MASK, 32'hffffffff);
    apb(1'b1, `DOR_OFF_FORCE, 32'h0);
    apb(1'b1, `DOR_OFF_ROUTE_EN, 32'h1);
    foreach (rte_t[i])
    begin
      {w, cw, ex} = rte_t[i];
      apb(1'b1, `DOR_OFF_ROUTE0, {16'h0, w});
      apb(1'b1, `DOR_OFF_ROUTE0 + 12'h004, {16'h0, w});
      apb(1'b1, `DOR_OFF_CMD, {24'h0, cw});
      settle;
      chk({30'h0, ex}, {30'h0, swpwm, line[0]});
    end
    $display("routing test done");
    // Soft PWM takes encoder divided by 2, so only every second change pulses
    apb(1'b1, `DOR_OFF_ROUTE0, 32'h0305);
    apb(1'b1, `DOR_OFF_ROUTE0 + 12'h004, 32'h0205);
    apb(1'b1, `DOR_OFF_ROUTE0 + 12'h008, 32'h0905);
    apb(1'b1, `DOR_OFF_CMD, 32'h20);
    settle;
    chk(32'h0, {29'h0, swpwm, line[1:0]});
    apb(1'b1, `DOR_OFF_ENC, 32'h1);
    apb(1'b1, `DOR_OFF_POS, 32'h1);
    settle;
    chk(32'h3, {29'h0, swpwm, line[1:0]});
    repeat (40010) @(posedge clk);
    #1;
    chk(32'h0, {29'h0, swpwm, line[1:0]});
    apb(1'b1, `DOR_OFF_ENC, 32'h2);
    settle;
    chk(32'h5, {29'h0, swpwm, line[1:0]});
    $display("pulse test done");
    close_out;
  end
endmodule // dor_top_tb
`default_nettype wire

// >>> hdl/dor_consts.vh
`ifndef DOR_CONSTS_VH
`define DOR_CONSTS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define DOR_OFF_CMD      12'h000
`define DOR_OFF_POL      12'h004
`define DOR_OFF_MASK     12'h008
`define DOR_OFF_FORCE    12'h00c
`define DOR_OFF_READBACK 12'h010
`define DOR_OFF_ROUTE_EN 12'h014
`define DOR_OFF_LED      12'h018
`define DOR_OFF_PWM_FREQ 12'h01c
`define DOR_OFF_PWM_DUTY 12'h020
`define DOR_OFF_ENC      12'h024
`define DOR_OFF_POS      12'h028
`define DOR_OFF_ROUTE0   12'h040
// ****************************************
// Field positions and widths
// ****************************************
`define DOR_NOUT         4
`define DOR_NROUTE       5
`define DOR_OUT_BIT0     16
`define DOR_BRAKE_BIT    0
`define DOR_LED_GREEN    0
`define DOR_LED_RED      1
`define DOR_GATE_INV_BIT 7
// ****************************************
// Source codes and reset values
// ****************************************
`define DOR_SRC_ONE      8'h00
`define DOR_SRC_ZERO     8'h01
`define DOR_SRC_ENC0     8'h02
`define DOR_SRC_ENC_LAST 8'h08
`define DOR_SRC_POS0     8'h09
`define DOR_SRC_POS_LAST 8'h0f
`define DOR_SRC_PWM      8'h10
`define DOR_SRC_PWM_INV  8'h11
`define DOR_ROUTE_OFF    16'hffff
`define DOR_RST_FREQ     12'h3e8
`define DOR_RST_DUTY     7'h32
`define DOR_FREQ_MIN     12'h032
`define DOR_FREQ_MAX     12'h7d0
`define DOR_DUTY_MIN     7'h02
`define DOR_DUTY_MAX     7'h64
// ****************************************
// Timing
// ****************************************
`define DOR_CLK_HZ       28'hbebc200
`define DOR_PULSE_NS     200000
// 200 us at 200 MHz, sized to the stretcher counter
`define DOR_PULSE_CYC    16'h9c40
`define DOR_SWPWM_NS     200000
`endif

// >>> hdl/dor_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dor_consts.vh"
module dor_top
(
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg  [3:0]  out_pin_o,
  output reg  [3:0]  out_oe_o,
  output reg         brake_o,
  output reg         swpwm_o,
  output reg         led_green_o,
  output reg         led_red_o
);

  // ****************************************
  // Registers
  // ****************************************
  reg [31:0] cmd_r;
  reg [31:0] pol_r;
  reg [31:0] mask_r;
  reg [31:0] force_r;
  reg        route_en_r;
  reg [1:0]  led_r;
  reg [11:0] freq_r;
  reg [6:0]  duty_r;
  reg [31:0] enc_r;
  reg [31:0] pos_r;
  reg [15:0] route_r [0:`DOR_NROUTE-1];
  reg [31:0] enc_prev_r;
  reg [31:0] pos_prev_r;
  reg [5:0]  enc_div_r;
  reg [5:0]  pos_div_r;
  reg [6:0]  enc_tick_r;
  reg [6:0]  pos_tick_r;
  reg [27:0] pwm_cnt_r;
  reg [27:0] pwm_per_r;
  reg [31:0] readback_r;
  reg [15:0] pulse_cnt_r [0:`DOR_NROUTE-1];
  reg [`DOR_NROUTE-1:0] pulse_r;
  wire       pwm_sig;
  wire       wr_en;
  integer    i;
  integer    k;

  // APB access phase completes in one cycle
  assign wr_en = psel_i & penable_i & pwrite_i;

  // Routed PWM high while counter below duty share of period
  assign pwm_sig = (duty_r == `DOR_DUTY_MAX) ? 1'b1 :
                   (({7'h0, pwm_cnt_r} * 35'h64) < ({7'h0, pwm_per_r} * {28'h0, duty_r}));

  // ****************************************
  // Helper functions
  // ****************************************
  // Pulse tick bit for divider 2^k from a change counter
  function sel_tick;
    input [6:0] ticks;
    input [2:0] k;
    begin
      sel_tick = ticks[k];
    end
  endfunction

  // Gate test with optional inversion
  function gate_on;
    input [31:0] cmd;
    input [7:0]  gsel;
    begin
      gate_on = cmd[gsel[4:0]] ^ gsel[`DOR_GATE_INV_BIT];
    end
  endfunction

  // ****************************************
  // APB register writes
  // ****************************************
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cmd_r      <= 32'h0000_0000;
      pol_r      <= 32'h0000_0000;
      mask_r     <= 32'h0000_0000;
      force_r    <= 32'h0000_0000;
      route_en_r <= 1'b0;
      led_r      <= 2'h0;
      freq_r     <= `DOR_RST_FREQ;
      duty_r     <= `DOR_RST_DUTY;
      enc_r      <= 32'h0000_0000;
      pos_r      <= 32'h0000_0000;
      for (i = 0; i < `DOR_NROUTE; i = i + 1)
        route_r[i] <= `DOR_ROUTE_OFF;
    end
    else if (wr_en)
    begin
      if (paddr_i == `DOR_OFF_CMD)
        cmd_r <= pwdata_i;
      else if (paddr_i == `DOR_OFF_POL)
        pol_r <= pwdata_i;
      else if (paddr_i == `DOR_OFF_MASK)
        mask_r <= pwdata_i;
      else if (paddr_i == `DOR_OFF_FORCE)
        force_r <= pwdata_i;
      else if (paddr_i == `DOR_OFF_ROUTE_EN)
        route_en_r <= pwdata_i[0];
      else if (paddr_i == `DOR_OFF_LED)
        led_r <= pwdata_i[1:0];
      else if (paddr_i == `DOR_OFF_PWM_FREQ)
      begin
        // Out-of-range frequency is dropped, old setting kept
        if (pwdata_i >= {20'h0, `DOR_FREQ_MIN} && pwdata_i <= {20'h0, `DOR_FREQ_MAX})
          freq_r <= pwdata_i[11:0];
      end
      else if (paddr_i == `DOR_OFF_PWM_DUTY)
      begin
        if (pwdata_i >= {25'h0, `DOR_DUTY_MIN} && pwdata_i <= {25'h0, `DOR_DUTY_MAX})
          duty_r <= pwdata_i[6:0];
      end
      else if (paddr_i == `DOR_OFF_ENC)
        enc_r <= pwdata_i;
      else if (paddr_i == `DOR_OFF_POS)
        pos_r <= pwdata_i;
      else if (paddr_i >= `DOR_OFF_ROUTE0 &&
               paddr_i < `DOR_OFF_ROUTE0 + 12'h4 * `DOR_NROUTE)
        route_r[paddr_i[4:2]] <= pwdata_i[15:0];
    end
  end

  // ****************************************
  // APB read and answer
  // ****************************************
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      // Ready in first access cycle, so transfer is always two cycles
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (psel_i & ~penable_i & ~pwrite_i)
      begin
        if (paddr_i == `DOR_OFF_CMD)
          prdata_o <= cmd_r;
        else if (paddr_i == `DOR_OFF_POL)
          prdata_o <= pol_r;
        else if (paddr_i == `DOR_OFF_MASK)
          prdata_o <= mask_r;
        else if (paddr_i == `DOR_OFF_FORCE)
          prdata_o <= force_r;
        else if (paddr_i == `DOR_OFF_READBACK)
          prdata_o <= readback_r;
        else if (paddr_i == `DOR_OFF_ROUTE_EN)
          prdata_o <= {31'h0, route_en_r};
        else if (paddr_i == `DOR_OFF_LED)
          prdata_o <= {30'h0, led_r};
        else if (paddr_i == `DOR_OFF_PWM_FREQ)
          prdata_o <= {20'h0, freq_r};
        else if (paddr_i == `DOR_OFF_PWM_DUTY)
          prdata_o <= {25'h0, duty_r};
        else if (paddr_i == `DOR_OFF_ENC)
          prdata_o <= enc_r;
        else if (paddr_i == `DOR_OFF_POS)
          prdata_o <= pos_r;
        else if (paddr_i >= `DOR_OFF_ROUTE0 &&
                 paddr_i < `DOR_OFF_ROUTE0 + 12'h4 * `DOR_NROUTE)
          prdata_o <= {16'h0, route_r[paddr_i[4:2]]};
      end
    end
  end

  // ****************************************
  // Change detectors and dividers
  // ****************************************
  // Divider counters wrap, bit k toggles every 2^k changes
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      enc_prev_r <= 32'h0000_0000;
      pos_prev_r <= 32'h0000_0000;
      enc_div_r  <= 6'h00;
      pos_div_r  <= 6'h00;
      enc_tick_r <= 7'h00;
      pos_tick_r <= 7'h00;
    end
    else
    begin
      enc_prev_r <= enc_r;
      pos_prev_r <= pos_r;
      enc_tick_r <= 7'h00;
      pos_tick_r <= 7'h00;
      if (enc_r != enc_prev_r)
      begin
        // Tick for divider 2^k on every 2^k-th change
        enc_div_r  <= enc_div_r + 6'h01;
        enc_tick_r <= {&enc_div_r[5:0], &enc_div_r[4:0], &enc_div_r[3:0], &enc_div_r[2:0],
                       &enc_div_r[1:0], enc_div_r[0], 1'b1};
      end
      if (pos_r != pos_prev_r)
      begin
        pos_div_r  <= pos_div_r + 6'h01;
        pos_tick_r <= {&pos_div_r[5:0], &pos_div_r[4:0], &pos_div_r[3:0], &pos_div_r[2:0],
                       &pos_div_r[1:0], pos_div_r[0], 1'b1};
      end
    end
  end

  // ****************************************
  // Routed PWM generator
  // ****************************************
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pwm_cnt_r <= 28'h0;
      pwm_per_r <= 28'h0030d40;
    end
    else
    begin
      // Period in clocks; division is slow but only re-evaluated per period
      if (pwm_cnt_r + 28'h1 >= pwm_per_r)
      begin
        pwm_cnt_r <= 28'h0;
        pwm_per_r <= `DOR_CLK_HZ / {16'h0, freq_r};
      end
      else
        pwm_cnt_r <= pwm_cnt_r + 28'h1;
    end
  end

  // ****************************************
  // Pulse stretchers per route
  // ****************************************
  // Each tick gives a fixed-width high pulse, suiting up to 500 Hz loads
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pulse_r <= {`DOR_NROUTE{1'b0}};
      for (k = 0; k < `DOR_NROUTE; k = k + 1)
        pulse_cnt_r[k] <= 16'h0;
    end
    else
    begin
      for (k = 0; k < `DOR_NROUTE; k = k + 1)
      begin
        if ((route_r[k][15:8] >= `DOR_SRC_ENC0 && route_r[k][15:8] <= `DOR_SRC_ENC_LAST &&
             sel_tick(enc_tick_r, route_r[k][10:8] - 3'h2)) ||
            (route_r[k][15:8] >= `DOR_SRC_POS0 && route_r[k][15:8] <= `DOR_SRC_POS_LAST &&
             sel_tick(pos_tick_r, route_r[k][10:8] - 3'h1)))
        begin
          pulse_cnt_r[k] <= `DOR_PULSE_CYC;
          pulse_r[k]     <= 1'b1;
        end
        else if (pulse_cnt_r[k] != 16'h0)
          pulse_cnt_r[k] <= pulse_cnt_r[k] - 16'h1;
        else
          pulse_r[k] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Output computation
  // ****************************************
  reg [31:0] applied_nxt;
  reg        swpwm_nxt;
  reg [7:0]  src;
  reg        val;
  integer    j;
  always @*
  begin
    // Normal path: force-or-command, then polarity
    applied_nxt = ((mask_r & force_r) | (~mask_r & cmd_r)) ^ pol_r;
    swpwm_nxt   = 1'b0;
    src         = 8'h00;
    val         = 1'b0;
    for (j = 0; j < `DOR_NROUTE; j = j + 1)
    begin
      src = route_r[j][15:8];
      if (src == `DOR_SRC_ONE)
        val = 1'b1;
      else if (src == `DOR_SRC_PWM)
        val = pwm_sig;
      else if (src == `DOR_SRC_PWM_INV)
        val = ~pwm_sig;
      else if (src <= `DOR_SRC_POS_LAST && src != `DOR_SRC_ZERO)
        val = pulse_r[j];
      else
        val = 1'b0;
      val = val & gate_on(cmd_r, route_r[j][7:0]);
      // Routing overrides the config path; all-ones leaves the normal value
      if (route_en_r && route_r[j] != `DOR_ROUTE_OFF)
      begin
        if (j == 0)
          swpwm_nxt = val;
        else
          applied_nxt[`DOR_OUT_BIT0 + j - 1] = val;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      readback_r  <= 32'h0000_0000;
      out_pin_o   <= 4'h0;
      out_oe_o    <= 4'h0;
      brake_o     <= 1'b0;
      swpwm_o     <= 1'b0;
      led_green_o <= 1'b0;
      led_red_o   <= 1'b0;
    end
    else
    begin
      readback_r  <= applied_nxt;
      out_pin_o   <= applied_nxt[`DOR_OUT_BIT0 +: `DOR_NOUT];
      // Open drain: pull low when level is 0
      out_oe_o    <= ~applied_nxt[`DOR_OUT_BIT0 +: `DOR_NOUT];
      brake_o     <= applied_nxt[`DOR_BRAKE_BIT];
      swpwm_o     <= swpwm_nxt;
      led_green_o <= led_r[`DOR_LED_GREEN];
      led_red_o   <= led_r[`DOR_LED_RED];
    end
  end

endmodule // dor_top
`default_nettype wire
